// ===== rtl/adcrc_pkg.sv
package adcrc_pkg;
   // register map of the plain register port
   localparam logic [2:0] ADDR_CHAN_REF_SEL = 3'h0;
   localparam logic [2:0] ADDR_CONTROL      = 3'h1;
   localparam logic [2:0] ADDR_RESULT_LOW   = 3'h2;
   localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h3;
   localparam logic [2:0] ADDR_STATUS       = 3'h4;

   // channel_reference_select fields
   localparam int REF_SEL_MSB = 7;
   localparam int REF_SEL_LSB = 6;
   localparam int LEFT_ALIGN_BIT = 5;
   localparam logic [7:0] CHAN_REF_SEL_RESET = 8'h00;

   // control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_START_BIT  = 6;
   localparam int CTL_DONE_BIT   = 4;
   localparam int CTL_IRQ_EN_BIT = 3;
   localparam int CTL_DIFF_BIT   = 2;

   // reference selector codes
   localparam logic [1:0] REF_EXT_PIN  = 2'h0;
   localparam logic [1:0] REF_SUPPLY   = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_INT_2V56 = 2'h3;

   // result codes
   localparam logic [9:0] SE_MAX   = 10'h3FF;
   localparam logic [9:0] DIFF_MAX = 10'h1FF;
   localparam logic [9:0] DIFF_MIN = 10'h200;
   localparam logic [11:0] SE_FULL = 12'h400;

   // conversion time in system clocks
   localparam int CONV_TIME_NS = 104;
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [7:0] CONV_CYCLES = 8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ADCRC_IDLE = 3'b001,
      ADCRC_CONV = 3'b010,
      ADCRC_DONE = 3'b100
   } adcrc_state_e;
endpackage : adcrc_pkg

// ===== rtl/adcrc_format.sv
`timescale 1ns/10ps
module adcrc_format (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // raw sample and mode
   input  wire logic [11:0] i_sample,
   input  wire logic       i_diff,
   // coded result
   output logic [9:0]      o_code
);
   logic [9:0] code_d;
   logic [9:0] code_q;

   // sample is signed 12-bit for differential, unsigned for single ended
   always_comb begin
      if (i_diff) begin
         if ($signed(i_sample) > $signed({2'h0, adcrc_pkg::DIFF_MAX})) begin
            code_d = adcrc_pkg::DIFF_MAX;
         end else if ($signed(i_sample) < $signed({2'h3, adcrc_pkg::DIFF_MIN})) begin
            code_d = adcrc_pkg::DIFF_MIN;
         end else begin
            code_d = i_sample[9:0];
         end
      end else if (i_sample >= adcrc_pkg::SE_FULL) begin
         code_d = adcrc_pkg::SE_MAX;
      end else begin
         code_d = i_sample[9:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         code_q <= 10'h000;
      end else begin
         code_q <= code_d;
      end
   end

   assign o_code = code_q;

   diff_sign_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_diff |=> o_code[9] == $past(i_sample[11]))
      else $error("sign bit wrong");
   se_clip_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (!i_diff && i_sample >= adcrc_pkg::SE_FULL) |=> o_code == adcrc_pkg::SE_MAX)
      else $error("single ended overrange wrapped");
endmodule // adcrc_format

// ===== rtl/adcrc_top.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module adcrc_top (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   // register port
   input  wire logic [2:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [7:0]       o_rdata,
   // cpu sleep controller
   input  wire logic        i_cpu_halted,
   input  wire logic        i_sleep_adc_mode,
   input  wire logic        i_irq_ack,
   // analog front end
   input  wire logic [11:0] i_sample,
   output logic [1:0]       o_ref_active,
   output logic             o_conv_busy,
   output logic             o_analog_power,
   // interrupt request to cpu
   output logic             o_irq
);
   typedef struct packed {
      adcrc_pkg::adcrc_state_e state;
      logic [7:0] chan_ref_sel;
      logic [1:0] ref_active;
      logic       enable;
      logic       irq_en;
      logic       diff;
      logic       done;
      logic [7:0] count;
      logic [9:0] result;
      logic       sleep_armed;
      logic [7:0] rdata;
      logic       irq;
      logic       busy;
   } adcrc_state_s;

   adcrc_state_s s_q;
   adcrc_state_s s_d;
   logic [9:0]   code;
   logic [7:0]   res_low;
   logic [7:0]   res_high;
   logic         wr_ctl;
   logic         start_sw;
   logic         start_sleep;
   logic [11:0]  sample_q1;
   logic [11:0]  sample_q2;

   // analog code arrives asynchronously; two stages before use
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sample_q1 <= 12'h000;
         sample_q2 <= 12'h000;
      end else begin
         sample_q1 <= i_sample;
         sample_q2 <= sample_q1;
      end
   end

   adcrc_format u_format (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_sample  (sample_q2),
      .i_diff    (s_q.diff),
      .o_code    (code)
   );

   // presentation is combinational from the stored result
   always_comb begin
      if (s_q.chan_ref_sel[adcrc_pkg::LEFT_ALIGN_BIT]) begin
         res_high = s_q.result[9:2];
         res_low  = {s_q.result[1:0], 6'h00};
      end else begin
         res_high = {6'h00, s_q.result[9:8]};
         res_low  = s_q.result[7:0];
      end
   end

   assign wr_ctl = i_wr && (i_addr == adcrc_pkg::ADDR_CONTROL);
   assign start_sw = wr_ctl && i_wdata[adcrc_pkg::CTL_START_BIT]
                     && (s_q.enable || i_wdata[adcrc_pkg::CTL_ENABLE_BIT]);
   // sleep start needs enabled, idle, irq enabled, adc sleep mode
   assign start_sleep = s_q.sleep_armed && i_cpu_halted;

   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      if (i_wr) begin
         unique case (i_addr)
            adcrc_pkg::ADDR_CHAN_REF_SEL: s_d.chan_ref_sel = i_wdata;
            adcrc_pkg::ADDR_CONTROL: begin
               s_d.enable = i_wdata[adcrc_pkg::CTL_ENABLE_BIT];
               s_d.irq_en = i_wdata[adcrc_pkg::CTL_IRQ_EN_BIT];
               s_d.diff   = i_wdata[adcrc_pkg::CTL_DIFF_BIT];
               if (i_wdata[adcrc_pkg::CTL_DONE_BIT]) begin
                  s_d.done = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (i_irq_ack) begin
         s_d.done = 1'b0;
      end
      if (i_rd) begin
         unique case (i_addr)
            adcrc_pkg::ADDR_CHAN_REF_SEL: s_d.rdata = s_q.chan_ref_sel;
            adcrc_pkg::ADDR_CONTROL: s_d.rdata = {s_q.enable, (s_q.state != adcrc_pkg::ADCRC_IDLE), 1'b0,
                                                  s_q.done, s_q.irq_en, s_q.diff, 2'h0};
            adcrc_pkg::ADDR_RESULT_LOW: s_d.rdata = res_low;
            adcrc_pkg::ADDR_RESULT_HIGH: s_d.rdata = res_high;
            adcrc_pkg::ADDR_STATUS: s_d.rdata = {6'h00, s_q.ref_active};
            default: s_d.rdata = 8'h00;
         endcase
      end
      // arm on sleep entry into adc sleep mode only
      s_d.sleep_armed = i_sleep_adc_mode && s_q.enable && s_q.irq_en
                        && (s_q.state == adcrc_pkg::ADCRC_IDLE) && !i_cpu_halted;
      unique case (s_q.state)
         adcrc_pkg::ADCRC_IDLE: begin
            // selector tracks the register while idle
            s_d.ref_active = s_q.chan_ref_sel[adcrc_pkg::REF_SEL_MSB:adcrc_pkg::REF_SEL_LSB];
            if (start_sw || (start_sleep && s_q.enable)) begin
               s_d.state = adcrc_pkg::ADCRC_CONV;
               s_d.count = adcrc_pkg::CONV_CYCLES;
               s_d.sleep_armed = 1'b0;
            end
         end
         adcrc_pkg::ADCRC_CONV: begin
            // selector frozen here
            s_d.count = s_q.count - 8'h01;
            if (!s_d.enable) begin
               s_d.state = adcrc_pkg::ADCRC_IDLE;
            end else if (s_q.count == 8'h01) begin
               s_d.state = adcrc_pkg::ADCRC_DONE;
            end
         end
         adcrc_pkg::ADCRC_DONE: begin
            s_d.result = code;
            s_d.done = 1'b1;
            s_d.ref_active = s_q.chan_ref_sel[adcrc_pkg::REF_SEL_MSB:adcrc_pkg::REF_SEL_LSB];
            s_d.state = adcrc_pkg::ADCRC_IDLE;
         end
         default: s_d.state = adcrc_pkg::ADCRC_IDLE;
      endcase
      // request stands while flag and enable are high, irrespective of wake source
      s_d.irq = s_d.done && s_d.irq_en;
      // busy kept as its own flop so the output is not a decode
      s_d.busy = (s_d.state != adcrc_pkg::ADCRC_IDLE);
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_q.state        <= adcrc_pkg::ADCRC_IDLE;
         s_q.chan_ref_sel <= adcrc_pkg::CHAN_REF_SEL_RESET;
         s_q.ref_active   <= adcrc_pkg::REF_EXT_PIN;
         s_q.enable       <= 1'b0;
         s_q.irq_en       <= 1'b0;
         s_q.diff         <= 1'b0;
         s_q.done         <= 1'b0;
         s_q.count        <= 8'h00;
         s_q.result       <= 10'h000;
         s_q.sleep_armed  <= 1'b0;
         s_q.rdata        <= 8'h00;
         s_q.irq          <= 1'b0;
         s_q.busy         <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // the done state overrides a same-cycle clear so no completion is lost
   assign o_rdata        = s_q.rdata;
   assign o_ref_active   = s_q.ref_active;
   assign o_conv_busy    = s_q.busy;
   // power follows the enable only; sleep does not drop it
   assign o_analog_power = s_q.enable;
   assign o_irq          = s_q.irq;

   ref_frozen_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_q.state == adcrc_pkg::ADCRC_CONV) |=> $stable(s_q.ref_active))
      else $error("reference moved mid conversion");
   done_sets_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_q.state == adcrc_pkg::ADCRC_DONE) |=> s_q.done && s_q.result == $past(code))
      else $error("done not set");
   sleep_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (start_sleep && s_q.state == adcrc_pkg::ADCRC_IDLE && s_q.enable) |=> o_conv_busy)
      else $error("sleep start missed");
   irq_raise_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_q.state == adcrc_pkg::ADCRC_DONE && s_q.irq_en && !i_wr) |=> o_irq)
      else $error("irq not raised");
   align_left_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_rd && i_addr == adcrc_pkg::ADDR_RESULT_HIGH && s_q.chan_ref_sel[5])
      |=> o_rdata == $past(s_q.result[9:2]))
      else $error("left align high byte wrong");
   align_right_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (i_rd && i_addr == adcrc_pkg::ADDR_RESULT_HIGH && !s_q.chan_ref_sel[5]) |=> o_rdata[7:2] == 6'h00)
      else $error("right align high byte wrong");
   power_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_analog_power == s_q.enable)
      else $error("power dropped");
   conv_len_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      ($rose(o_conv_busy) && s_q.count == adcrc_pkg::CONV_CYCLES) |-> ##13 s_q.state != adcrc_pkg::ADCRC_CONV)
      else $error("conversion too long");
   irq_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_irq == (s_q.done && s_q.irq_en))
      else $error("irq not following flag");
   rdata_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data without read");
   ref_track_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (s_q.state == adcrc_pkg::ADCRC_IDLE)
      |=> o_ref_active == $past(s_q.chan_ref_sel[adcrc_pkg::REF_SEL_MSB:adcrc_pkg::REF_SEL_LSB]))
      else $error("idle reference not tracking");
   busy_state_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_conv_busy == (s_q.state != adcrc_pkg::ADCRC_IDLE))
      else $error("busy disagrees with state");

   sleep_conv_c: cover property (@(posedge i_clk_sys) start_sleep ##[1:20] o_irq);
   sw_conv_c: cover property (@(posedge i_clk_sys) start_sw ##[1:20] s_q.done);
   ref_defer_c: cover property (@(posedge i_clk_sys) (s_q.state == adcrc_pkg::ADCRC_CONV) && i_wr
                                && i_addr == adcrc_pkg::ADDR_CHAN_REF_SEL);
   diff_conv_c: cover property (@(posedge i_clk_sys) s_q.diff && s_q.state == adcrc_pkg::ADCRC_DONE);
endmodule // adcrc_top

// ===== testbench/adcrc_cpu_model.sv
`timescale 1ns/10ps
module adcrc_cpu_model (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // sleep commands from the bench, interrupt request from the adc
   input  wire logic i_go,
   input  wire logic i_adc_sleep,
   input  wire logic i_wake,
   input  wire logic i_irq,
   // sleep controller outputs
   output logic      o_cpu_halted,
   output logic      o_sleep_adc_mode,
   output logic      o_irq_ack
);
   logic pend_q;

   always_ff @(posedge i_clk_sys) begin
      o_irq_ack <= 1'b0;
      if (i_rst) begin
         o_cpu_halted <= 1'b0;
         o_sleep_adc_mode <= 1'b0;
         pend_q <= 1'b0;
      end else if (i_go) begin
         // mode settles one cycle before the core halts
         o_sleep_adc_mode <= i_adc_sleep;
         pend_q <= 1'b1;
      end else if (pend_q) begin
         o_cpu_halted <= 1'b1;
         pend_q <= 1'b0;
      end else if (o_cpu_halted && (i_irq || i_wake)) begin
         o_cpu_halted <= 1'b0;
         o_sleep_adc_mode <= 1'b0;
         // vector taken only when the done interrupt did the waking
         o_irq_ack <= i_irq && !i_wake;
      end
   end
endmodule // adcrc_cpu_model

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
   logic        i_clk_sys = 1'b0;
   logic        i_rst = 1'b1;
   logic [2:0]  i_addr = 3'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [11:0] i_sample = 12'h000;
   logic        go = 1'b0;
   logic        adc_sleep = 1'b0;
   logic        wake = 1'b0;
   logic [7:0]  o_rdata, v;
   logic [1:0]  o_ref_active;
   logic        o_conv_busy, o_analog_power, o_irq, halted, smode, ack;
   logic [31:0] seed = 32'hDBBF;
   logic [1:0]  cur_ref = 2'h0;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [12:0] corner [10] = '{13'h0000, 13'h03FF, 13'h0400, 13'h0FFF, 13'h17FF,
                                13'h11FF, 13'h1000, 13'h1FFF, 13'h1E00, 13'h1800};

   always #4 i_clk_sys = ~i_clk_sys;

   adcrc_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cpu_halted(halted), .i_sleep_adc_mode(smode),
      .i_irq_ack(ack), .i_sample(i_sample), .o_ref_active(o_ref_active), .o_conv_busy(o_conv_busy),
      .o_analog_power(o_analog_power), .o_irq(o_irq));

   adcrc_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_go(go), .i_adc_sleep(adc_sleep),
      .i_wake(wake), .i_irq(o_irq), .o_cpu_halted(halted), .o_sleep_adc_mode(smode), .o_irq_ack(ack));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   function automatic logic [9:0] exp_code(input logic [11:0] s, input logic d);
      if (!d) return (s > 12'h3FF) ? adcrc_pkg::SE_MAX : s[9:0];
      if ($signed(s) > $signed(12'h1FF)) return adcrc_pkg::DIFF_MAX;
      if ($signed(s) < $signed(12'hE00)) return adcrc_pkg::DIFF_MIN;
      return s[9:0];
   endfunction

   task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (o_irq !== 1'b1 && n < 60) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      chk(10'(n < 60), 10'h1, "done wait");
   endtask

   task automatic sleep(input logic a);
      @(posedge i_clk_sys);
      go <= 1'b1;
      adc_sleep <= a;
      @(posedge i_clk_sys);
      go <= 1'b0;
   endtask

   task automatic conv(input logic [11:0] s, input logic d, input logic [1:0] r);
      logic [9:0] e;
      i_sample <= s;
      // off then on before a differential run so power is seen to drop
      if (d) begin
         wr(adcrc_pkg::ADDR_CONTROL, 8'h00);
         chk(10'(o_analog_power), 10'h0, "power off");
      end
      repeat (3) @(posedge i_clk_sys);
      wr(adcrc_pkg::ADDR_CONTROL, {5'b11001, d, 2'b00});
      wr(adcrc_pkg::ADDR_CHAN_REF_SEL, {r, 6'h00});
      repeat (2) @(posedge i_clk_sys);
      #1 chk(10'(o_ref_active), 10'(cur_ref), "ref held");
      wait_irq;
      chk(10'(o_ref_active), 10'(r), "ref applied");
      cur_ref = r;
      e = exp_code(s, d);
      for (int al = 0; al < 2; al++) begin
         wr(adcrc_pkg::ADDR_CHAN_REF_SEL, {r, al[0], 5'h00});
         rd(adcrc_pkg::ADDR_RESULT_HIGH, v);
         chk(10'(v), al ? 10'(e[9:2]) : 10'(e[9:8]), "high");
         rd(adcrc_pkg::ADDR_RESULT_LOW, v);
         chk(10'(v), al ? 10'({e[1:0], 6'h00}) : 10'(e[7:0]), "low");
      end
      wr(adcrc_pkg::ADDR_CONTROL, {5'b10011, d, 2'b00});
      @(posedge i_clk_sys);
      #1 chk(10'(o_irq), 10'h0, "irq clear");
      rd(adcrc_pkg::ADDR_RESULT_HIGH, v);
      chk(10'(v), 10'(e[9:2]), "held");
   endtask

   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 12000) begin
         mismatches++;
         $display("CHECK FAILED t=%0t run too long", $time);
         stop_test();
      end
   end

   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(adcrc_pkg::ADDR_CHAN_REF_SEL, v);
      chk(10'(v), 10'(adcrc_pkg::CHAN_REF_SEL_RESET), "reset value");
      rd(3'h7, v);
      chk(10'(v), 10'h0, "unmapped");
      for (int i = 0; i < 10; i++) conv(corner[i][11:0], corner[i][12], 2'(i));
      repeat (24) begin
         seed = xs(seed);
         conv(seed[11:0], seed[12], seed[14:13]);
      end
      wr(adcrc_pkg::ADDR_CONTROL, 8'h88);
      wr(adcrc_pkg::ADDR_CHAN_REF_SEL, 8'h00);
      i_sample <= 12'h123;
      sleep(1'b1);
      wait_irq;
      repeat (3) @(posedge i_clk_sys);
      #1 chk(10'(o_irq), 10'h0, "acked");
      rd(adcrc_pkg::ADDR_RESULT_LOW, v);
      chk(10'(v), 10'h23, "sleep result");
      sleep(1'b1);
      repeat (4) @(posedge i_clk_sys);
      wake <= 1'b1;
      @(posedge i_clk_sys);
      wake <= 1'b0;
      #1 chk(10'(o_conv_busy), 10'h1, "busy after wake");
      wait_irq;
      wr(adcrc_pkg::ADDR_CONTROL, 8'h98);
      sleep(1'b0);
      repeat (20) @(posedge i_clk_sys);
      #1 chk(10'(o_conv_busy), 10'h0, "no start");
      chk(10'(o_analog_power), 10'h1, "powered");
      wake <= 1'b1;
      @(posedge i_clk_sys);
      wake <= 1'b0;
      stop_test();
   end
endmodule // tb
